// ---- tcc_counter.sv ----
// 16-bit timer/counter base counter with capture channels
// Notes on behaviour
// - outside quadrature decoding, each timer clock pulse clears, reloads, increments or decrements the counter
// - normal mode counts one step per pulse in the direction bit's direction
// - counting up, after TOP the next pulse makes the counter zero
// - counting down, at BOTTOM the counter reloads with the period
// - software counter write is immediate and beats count, clear and reload
// - direction changes while running apply to following steps
// - event control supports event up/down counting and quadrature decode counting
// - 32-bit mode: low unit overflow event clocks the high unit
// - unbuffered period write is used in the TOP compare at once
// - new TOP below count counting up means no match; counter wraps
// - period buffer writable anytime; loaded into period only at UPDATE
// - source select triggers channel A, next event channels the next ones
// - enabled channels copy the counter into their capture register on capture
// - period below 0x8000: capture msb holds pin edge, one for rising
// - capture sets channel flag; buffer valid marks data in buffer
// - in input capture the counter runs BOTTOM to TOP freely
// - frequency capture: rising event captures and restarts the counter
// - pulse width: rising edge restarts, falling edge captures
// - TOP is the period or channel A value per waveform mode
// - UPDATE is flagged at BOTTOM or TOP per waveform mode
// - capture buffer moves into capture register when empty or read
`default_nettype none
`include "tcc_defs.svh"
module tcc_counter #(
  parameter int NUM_CH  = `TCC_NUM_CH,
  parameter int EVCH_W  = `TCC_EVCH_W
) (
  input  wire logic                      clk,
  input  wire logic                      rst,
  input  wire logic                      timerTick,
  input  wire logic                      countDown,
  input  wire tcc_pkg::tcc_event_action_select_t       eventActionSelect,
  input  wire logic [EVCH_W-1:0]         eventSourceSelect,
  input  wire logic [(1<<EVCH_W)-1:0]    eventIn,
  input  wire logic [(1<<EVCH_W)-1:0]    eventRise,
  input  wire logic                      qdecPhaseA,
  input  wire logic                      qdecPhaseB,
  input  wire tcc_pkg::tcc_topsel_t      topSelect,
  input  wire tcc_pkg::tcc_updsel_t      updateSelect,
  input  wire logic                      cntWrEn,
  input  wire logic [`TCC_CNT_W-1:0]     cntWrData,
  input  wire logic                      perWrEn,
  input  wire logic                      perBufWrEn,
  input  wire logic [`TCC_CNT_W-1:0]     perWrData,
  input  wire logic [NUM_CH-1:0]         chanEnable,
  input  wire logic [NUM_CH-1:0]         chanRead,
  input  wire logic [NUM_CH-1:0]         chanWrEn,
  input  wire logic [`TCC_CNT_W-1:0]     chanWrData,
  output logic [`TCC_CNT_W-1:0]          counter_value,
  output logic [`TCC_CNT_W-1:0]          period_value,
  output logic [`TCC_CNT_W-1:0]          period_buffer,
  output logic                           periodBufValid,
  output logic                           overflowEvent,
  output logic                           updateEvent,
  output logic [NUM_CH*`TCC_CNT_W-1:0]   channel_capture_value,
  output logic [NUM_CH*`TCC_CNT_W-1:0]   channel_capture_buffer,
  output logic [NUM_CH-1:0]              buffer_valid_flag,
  output logic [NUM_CH-1:0]              chanFlag
);
  import tcc_pkg::*;

  initial begin
    if (NUM_CH < 1 || NUM_CH > (1 << EVCH_W)) begin
      $error("channel count does not fit the event channels");
    end
  end

  logic [`TCC_CNT_W-1:0] cnt_r;
  logic [`TCC_CNT_W-1:0] cnt_nxt;
  logic [`TCC_CNT_W-1:0] per_r;
  logic [`TCC_CNT_W-1:0] period_buffer_r;
  logic                  perBv_r;
  logic [`TCC_CNT_W-1:0] topValue;
  logic                  atTop;
  logic                  atBottom;
  logic                  updateCond;
  logic                  stepUp;
  logic                  stepDown;
  logic                  restart;
  logic                  qdecA_r;
  logic                  qdecB_r;
  logic [NUM_CH-1:0]     chanEvent;
  logic [NUM_CH-1:0]     chanRise;
  logic [NUM_CH-1:0]     captTrig;
  logic [NUM_CH*`TCC_CNT_W-1:0] capVal;
  logic [NUM_CH*`TCC_CNT_W-1:0] capBuf;
  logic [NUM_CH-1:0]     capBv;
  logic [NUM_CH-1:0]     capFlag;

  function automatic logic [EVCH_W-1:0] evIndex(input logic [EVCH_W-1:0] base, input int ch);
    evIndex = base + EVCH_W'(ch);
  endfunction

  // channel A's value doubles as the TOP source when the waveform mode asks for it
  assign topValue   = (topSelect == TCC_TOP_CCA) ? capVal[`TCC_CNT_W-1:0] : per_r;
  assign atTop      = (cnt_r == topValue);
  assign atBottom   = (cnt_r == `TCC_BOTTOM);
  assign updateCond = timerTick &&
                      ((updateSelect == TCC_UPD_BOTTOM) ? atBottom : atTop);

  // event routing: channel n listens on event channel base+n, wrapping around
  always_comb begin
    for (int ch = 0; ch < NUM_CH; ch++) begin
      chanEvent[ch] = eventIn[evIndex(eventSourceSelect, ch)];
      chanRise[ch]  = eventRise[evIndex(eventSourceSelect, ch)];
    end
  end

  // capture actions per mode; restart only from enabled channels
  always_comb begin
    captTrig = '0;
    restart  = 1'b0;
    for (int ch = 0; ch < NUM_CH; ch++) begin
      if (chanEnable[ch] && chanEvent[ch]) begin
        unique case (eventActionSelect)
          TCC_EV_CAPT: captTrig[ch] = 1'b1;
          TCC_EV_FRQ: begin
            if (chanRise[ch]) begin
              captTrig[ch] = 1'b1;
              restart      = 1'b1;
            end
          end
          TCC_EV_PW: begin
            if (chanRise[ch]) begin
              restart = 1'b1;
            end else begin
              captTrig[ch] = 1'b1;
            end
          end
          default: ;
        endcase
      end
    end
  end

  // direction source: direction bit, event level or quadrature phase
  always_comb begin
    stepUp   = 1'b0;
    stepDown = 1'b0;
    unique case (eventActionSelect)
      TCC_EV_UPDN: begin
        stepUp   = timerTick && !eventIn[eventSourceSelect];
        stepDown = timerTick &&  eventIn[eventSourceSelect];
      end
      TCC_EV_QUADRATURE_DECODING: begin
        // an edge on either phase steps by one; the other phase decides the sense
        if (qdecA_r != qdecPhaseA) begin
          stepUp   = (qdecPhaseA != qdecPhaseB);
          stepDown = (qdecPhaseA == qdecPhaseB);
        end else if (qdecB_r != qdecPhaseB) begin
          stepUp   = (qdecPhaseA == qdecPhaseB);
          stepDown = (qdecPhaseA != qdecPhaseB);
        end
      end
      default: begin
        stepUp   = timerTick && !countDown;
        stepDown = timerTick &&  countDown;
      end
    endcase
  end

  always_comb begin
    cnt_nxt = cnt_r;
    if (cntWrEn) begin
      cnt_nxt = cntWrData;
    end else if (timerTick && restart) begin
      cnt_nxt = `TCC_BOTTOM;
    end else if (stepUp) begin
      // equality only: a TOP below the count lets it run on and wrap
      cnt_nxt = atTop ? `TCC_BOTTOM : cnt_r + 16'h0001;
    end else if (stepDown) begin
      cnt_nxt = atBottom ? per_r : cnt_r - 16'h0001;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_r <= `TCC_CNT_RST;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      qdecA_r <= 1'b0;
      qdecB_r <= 1'b0;
    end else begin
      qdecA_r <= qdecPhaseA;
      qdecB_r <= qdecPhaseB;
    end
  end

  // period and its buffer; a direct write beats a pending buffer load
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      per_r    <= `TCC_PER_RST;
      period_buffer_r <= `TCC_PER_RST;
      perBv_r  <= 1'b0;
    end else begin
      if (perBufWrEn) begin
        period_buffer_r <= perWrData;
      end
      if (perWrEn) begin
        per_r <= perWrData;
      end else if (updateCond && perBv_r) begin
        per_r <= period_buffer_r;
      end
      if (perBufWrEn) begin
        perBv_r <= 1'b1;
      end else if (updateCond) begin
        perBv_r <= 1'b0;
      end
    end
  end

  // low unit overflow drives the high unit's tick through the event system
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      overflowEvent <= 1'b0;
      updateEvent   <= 1'b0;
    end else begin
      overflowEvent <= !cntWrEn && !restart &&
                       ((stepUp && atTop) || (stepDown && atBottom));
      updateEvent   <= updateCond;
    end
  end

  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : gCh
      tcc_cap_if capBus ();
      assign capBus.countNow   = cnt_r;
      assign capBus.captTrig   = captTrig[g];
      assign capBus.edgeRise   = chanRise[g];
      assign capBus.polEnable  = (per_r < `TCC_POL_LIMIT);
      assign capBus.readStrobe = chanRead[g];
      assign capBus.wrEn       = chanWrEn[g];
      assign capBus.wrData     = chanWrData;
      assign capVal[g*`TCC_CNT_W +: `TCC_CNT_W] = capBus.captValue;
      assign capBuf[g*`TCC_CNT_W +: `TCC_CNT_W] = capBus.captBuffer;
      assign capBv[g]   = capBus.bufValid;
      assign capFlag[g] = capBus.flag;
      tcc_capture_channel uChan (
        .clk (clk),
        .rst (rst),
        .cap (capBus)
      );
    end
  endgenerate

  // outputs mirror internal flops; capture outputs are the channels' own flops
  assign counter_value          = cnt_r;
  assign period_value           = per_r;
  assign period_buffer          = period_buffer_r;
  assign periodBufValid         = perBv_r;
  assign channel_capture_value  = capVal;
  assign channel_capture_buffer = capBuf;
  assign buffer_valid_flag      = capBv;
  assign chanFlag               = capFlag;
endmodule
`default_nettype wire

// ---- tcc_defs.svh ----
// constants for the timer/counter with capture channels
`ifndef TCC_DEFS_SVH
`define TCC_DEFS_SVH
`define TCC_CNT_W        16
`define TCC_NUM_CH       4
`define TCC_EVCH_W       3
`define TCC_CNT_RST      16'h0000
`define TCC_PER_RST      16'hFFFF
`define TCC_BOTTOM       16'h0000
`define TCC_POL_LIMIT    16'h8000
`define TCC_MSB          15
`endif

// ---- tcc_pkg.sv ----
// types shared by the timer/counter with capture channels
`default_nettype none
`include "tcc_defs.svh"
package tcc_pkg;
  typedef enum logic [2:0] {
    TCC_EV_OFF   = 3'b000,
    TCC_EV_UPDN  = 3'b001,
    TCC_EV_QUADRATURE_DECODING  = 3'b010,
    TCC_EV_CAPT  = 3'b011,
    TCC_EV_FRQ   = 3'b100,
    TCC_EV_PW    = 3'b101
  } tcc_event_action_select_t;
  typedef enum logic [1:0] {
    TCC_TOP_PER  = 2'b00,
    TCC_TOP_CCA  = 2'b01
  } tcc_topsel_t;
  typedef enum logic [0:0] {
    TCC_UPD_TOP    = 1'b0,
    TCC_UPD_BOTTOM = 1'b1
  } tcc_updsel_t;
endpackage
`default_nettype wire

// ---- tcc_cap_if.sv ----
// counter-to-capture channel signals
`default_nettype none
`include "tcc_defs.svh"
interface tcc_cap_if;
  logic [`TCC_CNT_W-1:0] countNow;
  logic                  captTrig;
  logic                  edgeRise;
  logic                  polEnable;
  logic                  readStrobe;
  logic                  wrEn;
  logic [`TCC_CNT_W-1:0] wrData;
  logic [`TCC_CNT_W-1:0] captValue;
  logic [`TCC_CNT_W-1:0] captBuffer;
  logic                  bufValid;
  logic                  flag;
  modport counter (output countNow, captTrig, edgeRise, polEnable, readStrobe, wrEn, wrData,
                   input captValue, captBuffer, bufValid, flag);
  modport channel (input countNow, captTrig, edgeRise, polEnable, readStrobe, wrEn, wrData,
                   output captValue, captBuffer, bufValid, flag);
endinterface
`default_nettype wire

// ---- tcc_capture_channel.sv ----
// one capture channel: buffer and capture register as a two-entry queue
`default_nettype none
`include "tcc_defs.svh"
module tcc_capture_channel (
  input  wire logic   clk,
  input  wire logic   rst,
  tcc_cap_if.channel  cap
);
  import tcc_pkg::*;
  logic [`TCC_CNT_W-1:0] stamp;
  logic                  regFull_r;

  always_comb begin
    stamp = cap.countNow;
    if (cap.polEnable) begin
      stamp[`TCC_MSB] = cap.edgeRise;
    end
  end

  // set wins over read: a capture in the read cycle is kept
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cap.captValue  <= `TCC_CNT_RST;
      cap.captBuffer <= `TCC_CNT_RST;
      cap.bufValid   <= 1'b0;
      regFull_r      <= 1'b0;
    end else if (cap.wrEn) begin
      cap.captValue <= cap.wrData;
      regFull_r     <= 1'b1;
    end else begin
      if (cap.captTrig) begin
        if (!regFull_r || (cap.readStrobe && !cap.bufValid)) begin
          cap.captValue <= stamp;
          regFull_r     <= 1'b1;
          cap.bufValid  <= 1'b0;
        end else if (cap.readStrobe) begin
          cap.captValue  <= cap.captBuffer;
          cap.captBuffer <= stamp;
          cap.bufValid   <= 1'b1;
        end else if (!cap.bufValid) begin
          cap.captBuffer <= stamp;
          cap.bufValid   <= 1'b1;
        end
      end else if ((cap.readStrobe || !regFull_r) && cap.bufValid) begin
        cap.captValue <= cap.captBuffer;
        cap.bufValid  <= 1'b0;
        regFull_r     <= 1'b1;
      end else if (cap.readStrobe) begin
        regFull_r <= 1'b0;
      end
    end
  end

  assign cap.flag = regFull_r;
endmodule
`default_nettype wire

// ---- tcc_counter_assertions.sv ----
// assertions on the base counter and capture channel A
`default_nettype none
`include "tcc_defs.svh"
module tcc_counter_assertions (
  input wire logic                 clk,
  input wire logic                 rst,
  input wire logic                 timerTick,
  input wire logic                 countDown,
  input wire tcc_pkg::tcc_event_action_select_t  eventActionSelect,
  input wire logic [2:0]           eventSourceSelect,
  input wire logic [7:0]           eventIn,
  input wire logic [7:0]           eventRise,
  input wire tcc_pkg::tcc_topsel_t topSelect,
  input wire logic                 cntWrEn,
  input wire logic [15:0]          cntWrData,
  input wire logic                 perWrEn,
  input wire logic                 perBufWrEn,
  input wire logic [15:0]          perWrData,
  input wire logic [3:0]           chanEnable,
  input wire logic [3:0]           chanWrEn,
  input wire logic [15:0]          counter_value,
  input wire logic [15:0]          period_value,
  input wire logic                 periodBufValid,
  input wire logic [63:0]          channel_capture_value,
  input wire logic [3:0]           chanFlag
);
  import tcc_pkg::*;
  logic norm;
  logic selEv;
  logic selRise;
  // period traffic may move TOP in the same cycle, so plain counting checks stand aside
  assign norm = (eventActionSelect == TCC_EV_OFF || eventActionSelect == TCC_EV_CAPT)
    && topSelect == TCC_TOP_PER && !cntWrEn && !perWrEn && !perBufWrEn && !periodBufValid;
  assign selEv   = eventIn[eventSourceSelect];
  assign selRise = eventRise[eventSourceSelect];
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  property p_write; cntWrEn |=> counter_value == $past(cntWrData); endproperty
  a_write: assert property (p_write) else $error("counter write lost");
  property p_up;
    norm && timerTick && !countDown && counter_value != period_value
      |=> counter_value == $past(counter_value) + 16'h0001;
  endproperty
  a_up: assert property (p_up) else $error("up step wrong");
  property p_wrap;
    norm && timerTick && !countDown && counter_value == period_value |=> counter_value == 16'h0000;
  endproperty
  a_wrap: assert property (p_wrap) else $error("no clear after top");
  property p_reload;
    norm && timerTick && countDown && counter_value == 16'h0000
      |=> counter_value == $past(period_value);
  endproperty
  a_reload: assert property (p_reload) else $error("no reload at bottom");
  property p_hold; norm && !timerTick |=> $stable(counter_value); endproperty
  a_hold: assert property (p_hold) else $error("counter moved without tick");
  property p_perwr; perWrEn |=> period_value == $past(perWrData); endproperty
  a_perwr: assert property (p_perwr) else $error("direct period write lost");
  property p_period_buffer; !perWrEn && !periodBufValid |=> $stable(period_value); endproperty
  a_period_buffer: assert property (p_period_buffer) else $error("period changed without cause");
  property p_capt;
    eventActionSelect == TCC_EV_CAPT && selEv && chanEnable[0] && !chanFlag[0] && !chanWrEn[0]
      && period_value >= `TCC_POL_LIMIT
      |=> chanFlag[0] && channel_capture_value[15:0] == $past(counter_value);
  endproperty
  a_capt: assert property (p_capt) else $error("capture a wrong");
  property p_restart;
    (eventActionSelect == TCC_EV_FRQ || eventActionSelect == TCC_EV_PW) && selEv && selRise
      && chanEnable[0] && timerTick && !cntWrEn |=> counter_value == 16'h0000;
  endproperty
  a_restart: assert property (p_restart) else $error("restart missing");
  c_wrap: cover property (norm && timerTick && !countDown && counter_value == period_value);
  c_capt: cover property (eventActionSelect == TCC_EV_CAPT && selEv && chanEnable[0]);
  c_frq: cover property (eventActionSelect == TCC_EV_FRQ && selEv && selRise && timerTick);
endmodule
`default_nettype wire

// ---- tcc_event_source.sv ----
// event system model: edge events from a pin on the capture channels
`default_nettype none
module tcc_event_source (
  input  wire logic       clk,
  output var  logic [7:0] eventIn,
  output var  logic [7:0] eventRise
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    eventIn = 8'h00;
    eventRise = 8'h00;
  end
  // one pulse per sensed edge, both edges reported with their polarity
  task automatic pulse(input logic [2:0] ch, input logic rise);
    // one idle edge first so back-to-back pulses never re-raise in the lowering step
    @(posedge clk) #1;
    eventIn[ch] = 1'b1;
    eventRise = {8{rise}};
    @(posedge clk) #1;
    eventIn = 8'h00;
    // idle polarity lines flip so a stale value is never mistaken for a fresh one
    eventRise = ~eventRise;
  endtask
endmodule
`default_nettype wire

// ---- tcc_counter_test.sv ----
// self-checking bench for the timer/counter with capture channels
`default_nettype none
module tcc_counter_test;
  timeunit 1ns;
  timeprecision 1ns;
  import tcc_pkg::*;
  logic        clk, rst, timerTick, countDown, qdecPhaseA, qdecPhaseB;
  logic        cntWrEn, perWrEn, perBufWrEn, periodBufValid, overflowEvent, updateEvent;
  tcc_event_action_select_t  eventActionSelect;
  logic [2:0]  eventSourceSelect;
  logic [7:0]  eventIn, eventRise;
  logic [3:0]  chanEnable, chanRead, buffer_valid_flag, chanFlag;
  logic [15:0] cntWrData, perWrData, counter_value, period_value, period_buffer;
  logic [63:0] channel_capture_value, channel_capture_buffer;
  int          failures, tests_run, cycles, ovfSeen;
  tcc_event_source ev (.clk, .eventIn, .eventRise);
  tcc_counter uut (.clk, .rst, .timerTick, .countDown, .eventActionSelect, .eventSourceSelect,
    .eventIn, .eventRise, .qdecPhaseA, .qdecPhaseB, .topSelect(TCC_TOP_PER),
    .updateSelect(TCC_UPD_TOP), .cntWrEn, .cntWrData, .perWrEn, .perBufWrEn, .perWrData,
    .chanEnable, .chanRead, .chanWrEn(4'h0), .chanWrData(16'h0000), .counter_value,
    .period_value, .period_buffer, .periodBufValid, .overflowEvent, .updateEvent,
    .channel_capture_value, .channel_capture_buffer, .buffer_valid_flag, .chanFlag);
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (overflowEvent === 1'b1) ovfSeen++;
    if (cycles == 3000) begin
      failures++;
      $display("ERROR %0t: timeout", $time);
      results();
    end
  end
  task automatic results;
    $display("tests_run=%0d failures=%0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic tick(input int n);
    timerTick = 1'b1;
    cyc(n);
    timerTick = 1'b0;
    cyc(1);
  endtask
  task automatic wcnt(input logic [15:0] d);
    cntWrData = d;
    cntWrEn = 1'b1;
    cyc(1);
    cntWrEn = 1'b0;
  endtask
  task automatic wper(input logic [15:0] d, input logic useBuf);
    perWrData = d;
    perBufWrEn = useBuf;
    perWrEn = !useBuf;
    cyc(1);
    perWrEn = 1'b0;
    perBufWrEn = 1'b0;
  endtask
  task automatic doRst;
    rst = 1'b1;
    cyc(8);
    rst = 1'b0;
    cyc(1);
  endtask
  initial begin
    {timerTick, countDown, qdecPhaseA, qdecPhaseB, cntWrEn, perWrEn, perBufWrEn} = 7'h00;
    rst = 1'b1;
    eventActionSelect = TCC_EV_OFF;
    {eventSourceSelect, chanEnable, chanRead} = 11'h000;
    {cntWrData, perWrData} = 32'h0000_0000;
    doRst();
    chk(counter_value, 16'h0000);
    chk(period_value, 16'hFFFF);
    chk(16'({chanFlag, buffer_valid_flag}), 16'h0000);
    wper(16'h0005, 1'b0);
    chk(period_value, 16'h0005);
    for (int i = 1; i <= 7; i++) begin
      tick(1);
      chk(counter_value, 16'(i % 6));
    end
    chk(16'(ovfSeen), 16'h0001);
    countDown = 1'b1;
    tick(2);
    chk(counter_value, 16'h0005);
    tick(1);
    chk(counter_value, 16'h0004);
    countDown = 1'b0;
    timerTick = 1'b1;
    wcnt(16'h0009);
    timerTick = 1'b0;
    chk(counter_value, 16'h0009);
    tick(1);
    chk(counter_value, 16'h000A);
    wper(16'h0007, 1'b1);
    chk(period_buffer, 16'h0007);
    wcnt(16'h0004);
    chk(period_value, 16'h0005);
    tick(2);
    chk(period_value, 16'h0007);
    doRst();
    eventActionSelect = TCC_EV_CAPT;
    eventSourceSelect = 3'h2;
    chanEnable = 4'h3;
    wcnt(16'h1234);
    ev.pulse(3'h2, 1'b1);
    chk(channel_capture_value[15:0], 16'h1234);
    chk(16'(chanFlag), 16'h0001);
    ev.pulse(3'h3, 1'b1);
    chk(channel_capture_value[31:16], 16'h1234);
    ev.pulse(3'h4, 1'b1);
    chk(16'(chanFlag), 16'h0003);
    wcnt(16'h1235);
    ev.pulse(3'h2, 1'b1);
    chk(channel_capture_buffer[15:0], 16'h1235);
    chk(16'(buffer_valid_flag[0]), 16'h0001);
    chanRead = 4'h1;
    cyc(1);
    chanRead = 4'h0;
    chk(channel_capture_value[15:0], 16'h1235);
    wper(16'h7FFF, 1'b0);
    chanEnable = 4'hF;
    ev.pulse(3'h4, 1'b1);
    chk(channel_capture_value[47:32], 16'h9235);
    ev.pulse(3'h5, 1'b0);
    chk(channel_capture_value[63:48], 16'h1235);
    doRst();
    eventActionSelect = TCC_EV_FRQ;
    eventSourceSelect = 3'h0;
    chanEnable = 4'h1;
    timerTick = 1'b1;
    cyc(4);
    ev.pulse(3'h0, 1'b1);
    chk(counter_value, 16'h0000);
    chk(channel_capture_value[15:0], 16'h0005);
    doRst();
    eventActionSelect = TCC_EV_PW;
    timerTick = 1'b1;
    ev.pulse(3'h0, 1'b1);
    chk(counter_value, 16'h0000);
    cyc(2);
    ev.pulse(3'h0, 1'b0);
    timerTick = 1'b0;
    chk(channel_capture_value[15:0], 16'h0003);
    eventActionSelect = TCC_EV_UPDN;
    wcnt(16'h0008);
    fork
      ev.pulse(3'h0, 1'b1);
      begin
        cyc(1);
        tick(1);
      end
    join
    chk(counter_value, 16'h0007);
    tick(1);
    chk(counter_value, 16'h0008);
    eventActionSelect = TCC_EV_QUADRATURE_DECODING;
    qdecPhaseA = 1'b1;
    cyc(2);
    tests_run++;
    if (counter_value !== 16'h0007 && counter_value !== 16'h0009) begin
      failures++;
      $display("ERROR %0t: no quadrature step", $time);
    end
    results();
  end
endmodule
bind tcc_counter tcc_counter_assertions chk_i (.*);
`default_nettype wire
